// file: inc/flash_rsp_pkg.sv
// Constants and types shared by the run-time self-programming block
package flash_rsp_pkg;
   // ==========================================
   // Array geometry
   localparam int ROW_WORDS = 64;
   localparam int ROW_BYTES = 192;
   localparam int PAGE_ROWS = 8;
   localparam int PAGE_WORDS = ROW_WORDS * PAGE_ROWS;
   localparam int WORD_BITS = 24;
   localparam int HALF_BITS = 16;
   localparam int ADDR_BITS = 24;
   localparam int PC_BITS = 23;
   localparam int SLOT_BITS = 6;
   localparam int ROW_ALIGN_BITS = 7;
   localparam int PAGE_ALIGN_BITS = 10;
   // ==========================================
   // APB register map: index, byte address is four times it
   localparam int APB_ADDR_BITS = 12;
   localparam logic [APB_ADDR_BITS-1:0] TBL_PAGE_IDX = 12'h0032;
   localparam logic [APB_ADDR_BITS-1:0] CTRL_IDX = 12'h0038;
   localparam logic [APB_ADDR_BITS-1:0] KEY_IDX = 12'h0039;
   localparam logic [15:0] TBL_PAGE_RST = 16'h0000;
   localparam int TBL_PAGE_CFG_BIT = 7;
   localparam int TBL_PAGE_BITS = 8;
   // ==========================================
   // Control register fields
   localparam int CTRL_START_BIT = 15;
   localparam int CTRL_ERR_BIT = 13;
   localparam int CTRL_OP_LSB = 0;
   localparam logic [1:0] OP_WORD = 2'h1;
   localparam logic [1:0] OP_ROW = 2'h2;
   localparam logic [1:0] OP_PAGE = 2'h3;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 50;
   localparam int TBL_OP_CYCLES = 2;
   localparam int WORD_PROG_US = 50;
   localparam int ROW_PROG_US = 1600;
   localparam int PAGE_ERASE_US = 25000;
   localparam int WORD_PROG_CYC = WORD_PROG_US * CLK_MHZ;
   localparam int ROW_PROG_CYC = ROW_PROG_US * CLK_MHZ;
   localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
   // ==========================================
   // Sequencer states
   typedef enum logic [1:0] {
      st_idle,
      st_prog,
      st_erase,
      st_wait
   } seq_state_e;
endpackage : flash_rsp_pkg

// file: rtl/holding_buffer.sv
// Instruction holding buffer with separate low and high half writes
`timescale 1ns/1ps
`default_nettype none
module holding_buffer #(
   parameter int DEPTH = 64,
   parameter int LO_BITS = 16,
   parameter int HI_BITS = 8
) (
   // Clock
   input wire logic sys_clk_in,
   // Write port
   input wire logic wr_lo_in,
   input wire logic wr_hi_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_slot_in,
   input wire logic [LO_BITS-1:0] wr_data_in,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] rd_slot_in,
   output logic [LO_BITS+HI_BITS-1:0] rd_data_out
);
   logic [LO_BITS+HI_BITS-1:0] mem [DEPTH];

   // ==========================================
   // Elaboration checks
   if (DEPTH < 2 || HI_BITS > LO_BITS) begin : g_bad_param
      $error("holding_buffer: unsupported parameter values");
   end

   // ==========================================
   // Storage
   always_ff @(posedge sys_clk_in) begin
      if (wr_lo_in) begin
         mem[wr_slot_in][LO_BITS-1:0] <= wr_data_in;
      end
      if (wr_hi_in) begin
         mem[wr_slot_in][LO_BITS+HI_BITS-1:LO_BITS] <= wr_data_in[HI_BITS-1:0];
      end
   end

   assign rd_data_out = mem[rd_slot_in];
endmodule : holding_buffer
`default_nettype wire

// file: rtl/flash_row_self_programming.sv
// Run-time self-programming sequencer with APB registers and table port
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Array is organised in rows of 64 instructions, 192 bytes each.
// - Erase works on whole pages of eight rows, 512 instructions.
// - One operation programs a full row or a single word.
// - Pages align to 1536 bytes, rows to 192 bytes from memory start.
// - Holding buffer holds 64 instructions of pending data.
// - Table write is a two-cycle buffer write; array untouched.
// - Each started cycle programs at most one row.
// - Program address is 24 bits, from 23-bit counter or table page.
// - Counter-driven fetches stay in lower half, up to 0x7FFFFF.
// - Table page bit 7 opens configuration and identity area.
// - Unimplemented bits read zero; table page resets to 0000.
// - Start bit 15 launches; hardware clears it on completion.
// - Core is stalled while program or erase runs.
module flash_row_self_programming
   import flash_rsp_pkg::*;
#(
   parameter int BUF_DEPTH = ROW_WORDS,
   parameter int WORD_CYCLES = WORD_PROG_CYC,
   parameter int ROW_CYCLES = ROW_PROG_CYC,
   parameter int ERASE_CYCLES = PAGE_ERASE_CYC
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [APB_ADDR_BITS-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Core table operations
   input wire logic tbl_req_in,
   input wire logic tbl_write_in,
   input wire logic tbl_high_in,
   input wire logic [HALF_BITS-1:0] tbl_offset_in,
   input wire logic [HALF_BITS-1:0] tbl_wdata_in,
   output logic tbl_ack_out,
   output logic [HALF_BITS-1:0] tbl_rdata_out,
   output logic core_stall_out,
   // Core instruction fetch
   input wire logic [PC_BITS-1:0] fetch_pc_in,
   output logic [ADDR_BITS-1:0] fetch_addr_out,
   // Flash array
   output logic [ADDR_BITS-1:0] flash_addr_out,
   output logic [WORD_BITS-1:0] flash_wdata_out,
   output logic flash_rd_out,
   output logic flash_wr_out,
   output logic flash_erase_out,
   input wire logic [WORD_BITS-1:0] flash_rdata_in
);
   localparam int SB = $clog2(BUF_DEPTH);
   localparam int CW = 32;
   localparam logic [CW-1:0] CNT_LAST = 32'h0000_0001;

   // Register decode result
   typedef enum logic [1:0] {
      reg_none,
      reg_page,
      reg_ctrl,
      reg_key
   } reg_sel_e;

   // ==========================================
   // Elaboration checks
   if (BUF_DEPTH != ROW_WORDS) begin : g_bad_depth
      $error("flash_row_self_programming: buffer depth must equal one row");
   end
   if (WORD_CYCLES < 1) begin : g_bad_word
      $error("flash_row_self_programming: word time must be at least one cycle");
   end
   if (ROW_CYCLES < 1) begin : g_bad_row
      $error("flash_row_self_programming: row time must be at least one cycle");
   end
   if (ERASE_CYCLES < 1) begin : g_bad_erase
      $error("flash_row_self_programming: erase time must be at least one cycle");
   end

   // ==========================================
   // State
   typedef struct packed {
      seq_state_e st;
      logic [SB-1:0] slot;
      logic [CW-1:0] cnt;
      logic [1:0] op;
      logic start;
      logic err;
      logic key_half;
      logic unlocked;
      logic [TBL_PAGE_BITS-1:0] page;
      logic [ADDR_BITS-1:0] target;
      logic tbl_busy;
      logic tbl_rd;
      logic [SB-1:0] tbl_slot;
      logic tbl_ack;
      logic [HALF_BITS-1:0] tbl_rdata;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [ADDR_BITS-1:0] faddr;
      logic [WORD_BITS-1:0] fwdata;
      logic frd;
      logic fwr;
      logic ferase;
      logic [ADDR_BITS-1:0] fetch;
      logic stall;
   } state_s;

   state_s s_r;
   state_s s_nxt;
   logic [WORD_BITS-1:0] buf_rdata;
   logic buf_wr_lo;
   logic buf_wr_hi;
   logic [SB-1:0] buf_rd_slot;
   logic [ADDR_BITS-1:0] tbl_addr;
   logic apb_done;
   logic start_ok;
   reg_sel_e apb_reg;

   // ==========================================
   // Address helpers
   function automatic logic [SB-1:0] slot_of(input logic [ADDR_BITS-1:0] a);
      return a[SB:1];
   endfunction : slot_of

   function automatic logic [ADDR_BITS-1:0] align(input logic [ADDR_BITS-1:0] a, input int b);
      logic [ADDR_BITS-1:0] m;
      m = '1;
      return a & (m << b);
   endfunction : align

   function automatic logic [31:0] cycles_of(input logic [1:0] op);
      logic [31:0] c;
      c = 32'(WORD_CYCLES);
      if (op == OP_ROW) begin
         c = 32'(ROW_CYCLES);
      end else if (op == OP_PAGE) begin
         c = 32'(ERASE_CYCLES);
      end
      return c;
   endfunction : cycles_of

   function automatic reg_sel_e reg_of(input logic [APB_ADDR_BITS-1:0] a);
      reg_sel_e r;
      r = reg_none;
      if (a == (TBL_PAGE_IDX << 2)) begin
         r = reg_page;
      end else if (a == (CTRL_IDX << 2)) begin
         r = reg_ctrl;
      end else if (a == (KEY_IDX << 2)) begin
         r = reg_key;
      end
      return r;
   endfunction : reg_of

   // ==========================================
   // Holding buffer
   assign tbl_addr = {s_r.page, tbl_offset_in};
   assign buf_wr_lo = tbl_req_in && tbl_write_in && !tbl_high_in && !s_r.tbl_busy && !s_r.stall;
   assign buf_wr_hi = tbl_req_in && tbl_write_in && tbl_high_in && !s_r.tbl_busy && !s_r.stall;
   assign buf_rd_slot = (s_r.op == OP_WORD) ? slot_of(s_r.target) : s_r.slot;

   holding_buffer #(
      .DEPTH(BUF_DEPTH),
      .LO_BITS(HALF_BITS),
      .HI_BITS(WORD_BITS - HALF_BITS)
   ) u_buf (
      .sys_clk_in(sys_clk_in),
      .wr_lo_in(buf_wr_lo),
      .wr_hi_in(buf_wr_hi),
      .wr_slot_in(slot_of(tbl_addr)),
      .wr_data_in(tbl_wdata_in),
      .rd_slot_in(buf_rd_slot),
      .rd_data_out(buf_rdata)
   );

   assign apb_done = psel_in && penable_in && s_r.pready;
   assign start_ok = s_r.unlocked && (s_r.st == st_idle) &&
                     (pwdata_in[CTRL_OP_LSB+1:CTRL_OP_LSB] != 2'h0);
   assign apb_reg = reg_of(paddr_in);

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.tbl_ack = 1'b0;
      s_nxt.frd = 1'b0;
      s_nxt.fwr = 1'b0;
      s_nxt.ferase = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.fetch = {1'b0, fetch_pc_in};

      // Table operations: two cycles each, writes only reach the buffer
      if (s_r.tbl_busy) begin
         s_nxt.tbl_busy = 1'b0;
         s_nxt.tbl_ack = 1'b1;
         if (s_r.tbl_rd) begin
            s_nxt.tbl_rdata = tbl_high_in ?
               {{(2*HALF_BITS-WORD_BITS){1'b0}}, flash_rdata_in[WORD_BITS-1:HALF_BITS]} :
               flash_rdata_in[HALF_BITS-1:0];
         end
      end else if (tbl_req_in && !s_r.stall) begin
         s_nxt.tbl_busy = 1'b1;
         s_nxt.tbl_rd = !tbl_write_in;
         if (tbl_write_in) begin
            s_nxt.target = tbl_addr;
         end else begin
            s_nxt.frd = 1'b1;
            s_nxt.faddr = tbl_addr;
         end
      end

      // APB access phase: answer one cycle after access phase begins
      if (psel_in && penable_in && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = '0;
         if (apb_reg == reg_page) begin
            s_nxt.prdata[TBL_PAGE_BITS-1:0] = s_r.page;
         end else if (apb_reg == reg_ctrl) begin
            s_nxt.prdata[CTRL_START_BIT] = s_r.start;
            s_nxt.prdata[CTRL_ERR_BIT] = s_r.err;
            s_nxt.prdata[CTRL_OP_LSB+1:CTRL_OP_LSB] = s_r.op;
         end else if (apb_reg == reg_key) begin
            s_nxt.prdata = '0;
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end

      // APB write takes effect at the completing edge
      if (apb_done && pwrite_in) begin
         s_nxt.unlocked = 1'b0;
         s_nxt.key_half = 1'b0;
         if (apb_reg == reg_page) begin
            s_nxt.page = pwdata_in[TBL_PAGE_BITS-1:0];
         end else if (apb_reg == reg_key) begin
            if (pwdata_in[7:0] == KEY_FIRST) begin
               s_nxt.key_half = 1'b1;
            end else if (pwdata_in[7:0] == KEY_SECOND && s_r.key_half) begin
               s_nxt.unlocked = 1'b1;
            end
         end else if (apb_reg == reg_ctrl) begin
            s_nxt.err = 1'b0;
            if (s_r.st == st_idle) begin
               s_nxt.op = pwdata_in[CTRL_OP_LSB+1:CTRL_OP_LSB];
            end
            if (pwdata_in[CTRL_START_BIT]) begin
               if (start_ok) begin
                  s_nxt.start = 1'b1;
                  s_nxt.stall = 1'b1;
                  s_nxt.slot = '0;
                  s_nxt.st = (pwdata_in[CTRL_OP_LSB+1:CTRL_OP_LSB] == OP_PAGE) ?
                             st_erase : st_prog;
               end else begin
                  s_nxt.err = 1'b1;
               end
            end
         end
      end

      // Program and erase sequencer
      case (s_r.st)
         st_idle: begin
         end
         st_prog: begin
            s_nxt.fwr = 1'b1;
            s_nxt.fwdata = buf_rdata;
            if (s_r.op == OP_WORD) begin
               s_nxt.faddr = s_r.target;
               s_nxt.cnt = cycles_of(s_r.op);
               s_nxt.st = st_wait;
            end else begin
               s_nxt.faddr = align(s_r.target, ROW_ALIGN_BITS) |
                             {{(ADDR_BITS-SB-1){1'b0}}, s_r.slot, 1'b0};
               s_nxt.slot = s_r.slot + 1'b1;
               if (s_r.slot == SB'(BUF_DEPTH - 1)) begin
                  s_nxt.cnt = cycles_of(s_r.op);
                  s_nxt.st = st_wait;
               end
            end
         end
         st_erase: begin
            s_nxt.ferase = 1'b1;
            s_nxt.faddr = align(s_r.target, PAGE_ALIGN_BITS);
            s_nxt.cnt = cycles_of(s_r.op);
            s_nxt.st = st_wait;
         end
         st_wait: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            if (s_r.cnt <= CNT_LAST) begin
               s_nxt.start = 1'b0;
               s_nxt.stall = 1'b0;
               s_nxt.st = st_idle;
            end
         end
         default: begin
            s_nxt.st = st_idle;
         end
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         s_r <= '0;
         s_r.st <= st_idle;
         s_r.page <= TBL_PAGE_RST[TBL_PAGE_BITS-1:0];
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign prdata_out = s_r.prdata;
   assign pready_out = s_r.pready;
   assign pslverr_out = s_r.pslverr;
   assign tbl_ack_out = s_r.tbl_ack;
   assign tbl_rdata_out = s_r.tbl_rdata;
   assign core_stall_out = s_r.stall;
   assign fetch_addr_out = s_r.fetch;
   assign flash_addr_out = s_r.faddr;
   assign flash_wdata_out = s_r.fwdata;
   assign flash_rd_out = s_r.frd;
   assign flash_wr_out = s_r.fwr;
   assign flash_erase_out = s_r.ferase;
endmodule : flash_row_self_programming
`default_nettype wire

// file: sim/flash_rsp_assertions.sv
// Port checks for the self-programming block
`timescale 1ns/1ps
`default_nettype none
module flash_rsp_checker (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // Watched ports
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic [31:0] prdata_out,
   input wire logic tbl_req_in,
   input wire logic tbl_write_in,
   input wire logic tbl_ack_out,
   input wire logic core_stall_out,
   input wire logic [22:0] fetch_pc_in,
   input wire logic [23:0] fetch_addr_out,
   input wire logic [23:0] flash_addr_out,
   input wire logic flash_wr_out,
   input wire logic flash_erase_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========
   // Checks
   AST_APB_WAIT: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("apb answer late");
   AST_HI_ZERO: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
      else $error("upper read bits set");
   AST_FETCH_LOW: assert property (1 |=> fetch_addr_out == {1'b0, $past(fetch_pc_in)})
      else $error("fetch address wrong");
   AST_ACK_CAUSE: assert property (tbl_ack_out |-> $past(tbl_req_in, 2))
      else $error("ack without request");
   AST_TBLWR_BUF: assert property (tbl_req_in && tbl_write_in && !core_stall_out
      |=> (!flash_wr_out) [*2])
      else $error("table write hit array");
   AST_PROG_STALL: assert property (flash_wr_out || flash_erase_out |-> core_stall_out)
      else $error("array busy without stall");
   AST_ERASE_ALIGN: assert property (flash_erase_out |-> flash_addr_out[9:0] == 10'h000)
      else $error("erase not page aligned");
   AST_ROW_STEP: assert property (flash_wr_out && $past(flash_wr_out)
      |-> flash_addr_out == $past(flash_addr_out) + 24'h00_0002)
      else $error("row address step wrong");
endmodule : flash_rsp_checker
bind flash_row_self_programming flash_rsp_checker chk (
   .sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pready_out, .prdata_out,
   .tbl_req_in, .tbl_write_in, .tbl_ack_out, .core_stall_out, .fetch_pc_in,
   .fetch_addr_out, .flash_addr_out, .flash_wr_out, .flash_erase_out
);
`default_nettype wire

// file: sim/core_model.sv
// Core table port and flash array model
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // Clock
   input wire logic sys_clk_in,
   // Table port
   output logic tbl_req_out,
   output logic tbl_write_out,
   output logic tbl_high_out,
   output logic [15:0] tbl_offset_out,
   output logic [15:0] tbl_wdata_out,
   input wire logic tbl_ack_in,
   input wire logic [15:0] tbl_rdata_in,
   // Array
   input wire logic [23:0] flash_addr_in,
   output logic [23:0] flash_rdata_out
);
   // Array data follows the address
   assign flash_rdata_out = {flash_addr_in[7:0], flash_addr_in[23:8]};
   initial begin
      tbl_req_out = 1'b0;
      tbl_write_out = 1'b0;
      tbl_high_out = 1'b0;
      tbl_offset_out = 16'h0000;
      tbl_wdata_out = 16'h0000;
   end
   // One table operation, ok low if unanswered
   task automatic tbl_op(input logic w, input logic h, input logic [15:0] off,
      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
      int n;
      @(posedge sys_clk_in);
      tbl_req_out <= 1'b1;
      tbl_write_out <= w;
      tbl_high_out <= h;
      tbl_offset_out <= off;
      tbl_wdata_out <= wd;
      @(posedge sys_clk_in);
      tbl_req_out <= 1'b0;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 8) begin
         @(posedge sys_clk_in);
         ok = (tbl_ack_in === 1'b1);
         n++;
      end
      rd = tbl_rdata_in;
   endtask : tbl_op
endmodule : core_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the self-programming block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import flash_rsp_pkg::*;
   localparam logic [11:0] PG_A = {TBL_PAGE_IDX[9:0], 2'b00};
   localparam logic [11:0] CT_A = {CTRL_IDX[9:0], 2'b00};
   localparam logic [11:0] KY_A = {KEY_IDX[9:0], 2'b00};
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [22:0] pc = 23'h00_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, se, ack, stall, req, tw, th, fw, fe, ok, frp;
   logic [15:0] toff, twd, trd, td;
   logic [23:0] fetch_a, fa, fwd, frd;
   logic [23:0] wa [$];
   logic [23:0] wv [$];
   logic [23:0] ea [$];
   logic [23:0] ra [$];
   int failures = 0;
   int checks = 0;
   always #10 sys_clk = ~sys_clk;
   // ==========
   // Design and partner
   flash_row_self_programming #(.WORD_CYCLES(5), .ROW_CYCLES(5), .ERASE_CYCLES(5)) dut (
      .sys_clk_in(sys_clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .tbl_req_in(req), .tbl_write_in(tw),
      .tbl_high_in(th), .tbl_offset_in(toff), .tbl_wdata_in(twd), .tbl_ack_out(ack),
      .tbl_rdata_out(trd), .core_stall_out(stall), .fetch_pc_in(pc),
      .fetch_addr_out(fetch_a), .flash_addr_out(fa), .flash_wdata_out(fwd),
      .flash_rd_out(frp), .flash_wr_out(fw), .flash_erase_out(fe), .flash_rdata_in(frd));
   core_model core (.sys_clk_in(sys_clk), .tbl_req_out(req), .tbl_write_out(tw),
      .tbl_high_out(th), .tbl_offset_out(toff), .tbl_wdata_out(twd), .tbl_ack_in(ack),
      .tbl_rdata_in(trd), .flash_addr_in(fa), .flash_rdata_out(frd));
   // Record array pulses
   always @(posedge sys_clk) begin
      if (fw === 1'b1) begin
         wa.push_back(fa);
         wv.push_back(fwd);
      end
      if (fe === 1'b1) ea.push_back(fa);
      if (frp === 1'b1) ra.push_back(fa);
   end
   // ==========
   // Helpers
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic go(input logic [1:0] op);
      apb(1'b1, KY_A, {24'h00_0000, KEY_FIRST});
      apb(1'b1, KY_A, {24'h00_0000, KEY_SECOND});
      apb(1'b1, CT_A, {16'h0000, 1'b1, 13'h0000, op});
      @(posedge sys_clk);
      chk("stall", stall, 1);
      if (op == OP_ROW) begin
         core.tbl_op(1'b0, 1'b0, 16'h0000, 16'h0000, td, ok);
         chk("refused", ok, 0);
      end
      rd = 32'hFFFF_FFFF;
      for (int i = 0; i < 100 && rd[15] !== 1'b0; i++) apb(1'b0, CT_A, 32'h0000_0000);
      chk("start bit", rd[15], 0);
      chk("stall off", stall, 0);
   endtask : go
   // ==========
   // Scenarios
   task automatic t_regs;
      apb(1'b0, PG_A, 32'h0000_0000);
      chk("page reset", rd, 32'h0000_0000);
      apb(1'b1, PG_A, 32'hFFFF_FFFF);
      apb(1'b0, PG_A, 32'h0000_0000);
      chk("page bits", rd, 32'h0000_00FF);
      apb(1'b0, KY_A, 32'h0000_0000);
      chk("key read", rd, 32'h0000_0000);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("unmapped", se, 1);
      apb(1'b1, CT_A, 32'h0000_8002);
      apb(1'b0, CT_A, 32'h0000_0000);
      chk("locked err", rd[13], 1);
      chk("locked start", rd[15], 0);
      chk("locked wr", wa.size(), 0);
      apb(1'b1, CT_A, 32'h0000_0000);
      apb(1'b1, KY_A, {24'h00_0000, KEY_FIRST});
      apb(1'b1, KY_A, {24'h00_0000, KEY_SECOND});
      apb(1'b1, CT_A, 32'h0000_8000);
      apb(1'b0, CT_A, 32'h0000_0000);
      chk("no op err", rd[13], 1);
      chk("no op start", rd[15], 0);
      apb(1'b1, CT_A, 32'h0000_0000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_table;
      apb(1'b1, PG_A, 32'h0000_0080);
      core.tbl_op(1'b0, 1'b0, 16'h1234, 16'h0000, td, ok);
      chk("read ack", ok, 1);
      chk("read data", td, 16'h8012);
      chk("read pulses", ra.size(), 1);
      chk("read addr", ra[0], 24'h80_1234);
      apb(1'b1, PG_A, 32'h0000_0000);
      pc <= 23'h7F_FFFF;
      repeat (2) @(posedge sys_clk);
      chk("fetch", fetch_a, 24'h7F_FFFF);
      $display("test table done");
   endtask : t_table
   task automatic t_row;
      core.tbl_op(1'b1, 1'b0, 16'h018A, 16'hDEAD, td, ok);
      for (int i = 0; i < 64; i++) begin
         core.tbl_op(1'b1, 1'b0, 16'h0180 + 16'(2 * i), 16'hA000 + 16'(i), td, ok);
         chk("load ack", ok, 1);
         core.tbl_op(1'b1, 1'b1, 16'h0180 + 16'(2 * i), 16'(i + 64), td, ok);
      end
      chk("no array wr", wa.size(), 0);
      go(OP_ROW);
      chk("row count", wa.size(), 64);
      foreach (wa[i]) begin
         chk("row addr", wa[i], 24'h00_0180 + 24'(2 * i));
         chk("row data", wv[i], {8'(i + 64), 16'hA000 + 16'(i)});
      end
      $display("test row done");
   endtask : t_row
   task automatic t_word;
      core.tbl_op(1'b1, 1'b0, 16'h0106, 16'h1234, td, ok);
      core.tbl_op(1'b1, 1'b1, 16'h0106, 16'h0056, td, ok);
      wa.delete();
      wv.delete();
      go(OP_WORD);
      chk("word count", wa.size(), 1);
      chk("word addr", wa[0], 24'h00_0106);
      chk("word data", wv[0], 24'h56_1234);
      $display("test word done");
   endtask : t_word
   task automatic t_erase;
      core.tbl_op(1'b1, 1'b0, 16'h0A46, 16'h0000, td, ok);
      go(OP_PAGE);
      chk("erase count", ea.size(), 1);
      chk("erase addr", ea[0], 24'h00_0800);
      $display("test erase done");
   endtask : t_erase
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_table();
      t_row();
      t_word();
      t_erase();
      finish_test();
   end
   initial begin
      #(20 * 20000);
      failures++;
      finish_test();
   end
endmodule : testbench
`default_nettype wire
